// file: mpf_regs.vh
// Notes on behaviour
// - Memory write stores a byte, halfword or word for width codes 1, 2, 4.
// - Memory write places bytes little-endian on the byte lanes.
// - Flash program writes one byte at a 24-bit offset.
// - Program, block program and erase need flash write enable.
// - Program offsets 01_0000 to 7F_FFFF only; lower offsets give an error.
// - Programming only clears bits; setting bits needs a sector erase.
// - Sector erase sets every bit of the sector to one.
// - Sectors are sequential 64 KB; sector number is offset over 64 KB.
// - Erase accepts sectors 1 to 127; sector 0 gives an error.
// - Flash read returns the byte at any offset up to 7F_FFFF.
// - Block program fetches bytes from shared memory and programs them in order.
`ifndef MPF_REGS_VH
`define MPF_REGS_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define MPF_OP_MEMW 3'h0
`define MPF_OP_FPRG 3'h1
`define MPF_OP_FRD 3'h2
`define MPF_OP_FERS 3'h3
`define MPF_OP_FBLK 3'h4

// ----------------------------------------
// Flash operation codes
// ----------------------------------------
`define MPF_FL_READ 2'h0
`define MPF_FL_PROG 2'h1
`define MPF_FL_ERASE 2'h2

// ----------------------------------------
// Flash layout
// ----------------------------------------
`define MPF_FL_TOP 24'h7FFFFF
`define MPF_FL_USER_LO 24'h010000
`define MPF_SECT_SHIFT 16
`define MPF_SECT_MIN 32'h00000001
`define MPF_SECT_MAX 32'h0000007F

// ----------------------------------------
// Access widths and buffer
// ----------------------------------------
`define MPF_W_BYTE 3'h1
`define MPF_W_HALF 3'h2
`define MPF_W_WORD 3'h4
`define MPF_FIFO_DEPTH 8
`define MPF_FIFO_AW 3

`endif

// file: mpf_top.v
`timescale 1ns/1ps
`default_nettype none
`include "mpf_regs.vh"

// ----------------------------------------
// Byte buffer between shared memory and flash
// ----------------------------------------
module mpf_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = `MPF_FIFO_DEPTH,
	parameter AW = `MPF_FIFO_AW
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------
// Memory write and flash command handler
// ----------------------------------------
module mpf_top (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Command in
	input wire cmd_valid,
	output reg cmd_ready,
	input wire [2:0] cmd_op,
	input wire [31:0] cmd_addr,
	input wire [2:0] cmd_width,
	input wire [31:0] cmd_data,
	input wire [31:0] cmd_ptr,
	input wire [23:0] cmd_count,
	input wire flash_wr_enable,
	// Response out
	output reg rsp_valid,
	output reg rsp_err,
	output reg [7:0] rsp_data,
	// Processor-space write port
	output reg mem_req,
	output reg [31:0] mem_addr,
	output reg [31:0] mem_wdata,
	output reg [3:0] mem_be,
	input wire mem_ack,
	// Shared memory read port
	output reg shm_req,
	output reg [31:0] shm_addr,
	input wire shm_ack,
	input wire [7:0] shm_rdata,
	// Flash port
	output reg fl_req,
	output reg [1:0] fl_op,
	output reg [23:0] fl_addr,
	output reg [7:0] fl_wdata,
	input wire fl_ack,
	input wire [7:0] fl_rdata
);
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_MEMW = 6'h02;
	localparam [5:0] ST_FWT = 6'h04;
	localparam [5:0] ST_BLK = 6'h08;
	localparam [5:0] ST_RSP = 6'h10;

	reg [5:0] state_q;
	reg pre_q;
	reg blk_q;
	reg [7:0] data_q;
	reg [23:0] left_q;
	reg [23:0] fetch_left_q;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire fifo_pop;
	wire [24:0] blk_end;

	// Lane mask for an aligned access, zero when refused
	function [3:0] lane_mask;
		input [2:0] width;
		input [1:0] lo;
		begin
			if (width == `MPF_W_BYTE) begin
				lane_mask = 4'h1 << lo;
			end else if (width == `MPF_W_HALF && !lo[0]) begin
				lane_mask = 4'h3 << lo;
			end else if (width == `MPF_W_WORD && lo == 2'h0) begin
				lane_mask = 4'hF;
			end else begin
				lane_mask = 4'h0;
			end
		end
	endfunction

	// Programmable range, reserved sector excluded
	function in_user;
		input [31:0] off;
		begin
			// Upper address byte counts too, else it aliases into range
			in_user = (off[31:24] == 8'h00) && (off[23:0] >= `MPF_FL_USER_LO) &&
				(off[23:0] <= `MPF_FL_TOP);
		end
	endfunction

	assign fifo_pop = (state_q == ST_BLK) && fifo_out_valid;
	assign blk_end = {1'b0, cmd_addr[23:0]} + {1'b0, cmd_count} - 25'h1;

	mpf_fifo #(
		.WIDTH(8),
		.DEPTH(`MPF_FIFO_DEPTH),
		.AW(`MPF_FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(shm_req && shm_ack),
		.in_ready(fifo_in_ready),
		.in_data(shm_rdata),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cmd_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_err <= 1'b0;
			rsp_data <= 8'h00;
			mem_req <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_wdata <= 32'h00000000;
			mem_be <= 4'h0;
			shm_req <= 1'b0;
			shm_addr <= 32'h00000000;
			fl_req <= 1'b0;
			fl_op <= `MPF_FL_READ;
			fl_addr <= 24'h000000;
			fl_wdata <= 8'h00;
			pre_q <= 1'b0;
			blk_q <= 1'b0;
			data_q <= 8'h00;
			left_q <= 24'h000000;
			fetch_left_q <= 24'h000000;
		end else begin
			rsp_valid <= 1'b0;
			// ----------------------------------------
			// Shared memory fetch, one read outstanding
			// ----------------------------------------
			// Only asks when the buffer has room, so an answer never finds it full
			if (shm_req && shm_ack) begin
				shm_req <= 1'b0;
				shm_addr <= shm_addr + 32'h1;
				fetch_left_q <= fetch_left_q - 24'h1;
			end else if (!shm_req && fetch_left_q != 24'h0 && fifo_in_ready) begin
				shm_req <= 1'b1;
			end
			case (state_q)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					cmd_ready <= 1'b0;
					rsp_err <= 1'b0;
					rsp_data <= 8'h00;
					state_q <= ST_RSP;
					if (cmd_op == `MPF_OP_MEMW) begin
						if (lane_mask(cmd_width, cmd_addr[1:0]) == 4'h0) begin
							rsp_err <= 1'b1;
						end else begin
							mem_req <= 1'b1;
							mem_addr <= cmd_addr;
							mem_be <= lane_mask(cmd_width, cmd_addr[1:0]);
							// Lowest data byte goes to the lowest byte address
							mem_wdata <= cmd_data << {cmd_addr[1:0], 3'b000};
							state_q <= ST_MEMW;
						end
					end else if (cmd_op == `MPF_OP_FPRG) begin
						if (!flash_wr_enable || !in_user(cmd_addr)) begin
							rsp_err <= 1'b1;
						end else begin
							// Read first so the program can only clear bits
							fl_req <= 1'b1;
							fl_op <= `MPF_FL_READ;
							fl_addr <= cmd_addr[23:0];
							data_q <= cmd_data[7:0];
							pre_q <= 1'b1;
							blk_q <= 1'b0;
							state_q <= ST_FWT;
						end
					end else if (cmd_op == `MPF_OP_FRD) begin
						if (cmd_addr[23:0] > `MPF_FL_TOP || cmd_addr[31:24] != 8'h00) begin
							rsp_err <= 1'b1;
						end else begin
							fl_req <= 1'b1;
							fl_op <= `MPF_FL_READ;
							fl_addr <= cmd_addr[23:0];
							pre_q <= 1'b0;
							blk_q <= 1'b0;
							state_q <= ST_FWT;
						end
					end else if (cmd_op == `MPF_OP_FERS) begin
						if (!flash_wr_enable || cmd_addr < `MPF_SECT_MIN ||
								cmd_addr > `MPF_SECT_MAX) begin
							rsp_err <= 1'b1;
						end else begin
							fl_req <= 1'b1;
							fl_op <= `MPF_FL_ERASE;
							fl_addr <= {cmd_addr[7:0], 16'h0000};
							pre_q <= 1'b0;
							blk_q <= 1'b0;
							state_q <= ST_FWT;
						end
					end else if (cmd_op == `MPF_OP_FBLK) begin
						if (!flash_wr_enable || !in_user(cmd_addr) ||
								blk_end > {1'b0, `MPF_FL_TOP}) begin
							rsp_err <= 1'b1;
						end else if (cmd_count != 24'h0) begin
							fl_addr <= cmd_addr[23:0];
							left_q <= cmd_count;
							fetch_left_q <= cmd_count;
							shm_addr <= cmd_ptr;
							blk_q <= 1'b1;
							state_q <= ST_BLK;
						end
					end else begin
						rsp_err <= 1'b1;
					end
				end
			end
			ST_MEMW: begin
				if (mem_ack) begin
					mem_req <= 1'b0;
					state_q <= ST_RSP;
				end
			end
			ST_BLK: begin
				if (fifo_out_valid) begin
					data_q <= fifo_out_data;
					fl_req <= 1'b1;
					fl_op <= `MPF_FL_READ;
					pre_q <= 1'b1;
					state_q <= ST_FWT;
				end
			end
			ST_FWT: begin
				if (fl_ack) begin
					if (pre_q) begin
						pre_q <= 1'b0;
						fl_op <= `MPF_FL_PROG;
						fl_wdata <= fl_rdata & data_q;
					end else begin
						fl_req <= 1'b0;
						rsp_data <= fl_rdata;
						state_q <= ST_RSP;
						if (blk_q) begin
							left_q <= left_q - 24'h1;
							fl_addr <= fl_addr + 24'h1;
							if (left_q != 24'h1) begin
								state_q <= ST_BLK;
							end
						end
					end
				end
			end
			ST_RSP: begin
				rsp_valid <= 1'b1;
				cmd_ready <= 1'b1;
				blk_q <= 1'b0;
				state_q <= ST_IDLE;
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: mpf_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module mpf_sva (
	// Clock, reset, command
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [2:0] cmd_op,
	input wire logic flash_wr_enable,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	// Far side
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic fl_req,
	input wire logic [1:0] fl_op,
	input wire logic [23:0] fl_addr,
	input wire logic [7:0] fl_wdata,
	input wire logic fl_ack,
	input wire logic [7:0] fl_rdata
);
	logic [7:0] old_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Byte read before a program bounds its data
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			old_q <= 8'h00;
		else if (fl_req && fl_ack && fl_op == 2'h0)
			old_q <= fl_rdata;
	end
	sequence s_denied;
		cmd_valid && cmd_ready && !flash_wr_enable && cmd_op inside {3'h1, 3'h3, 3'h4};
	endsequence
	sequence s_prog;
		fl_req && fl_op == 2'h1;
	endsequence
	sequence s_erase;
		fl_req && fl_op == 2'h2;
	endsequence
	a_denied_quiet: assert property (s_denied |=> !fl_req ##1 rsp_valid && rsp_err)
		else $error("flash command ran while writes disabled");
	a_mem_finish: assert property (mem_req && mem_ack |=> !mem_req ##1 rsp_valid && !rsp_err)
		else $error("memory write did not finish");
	a_prog_clears: assert property (s_prog |-> (fl_wdata & ~old_q) == 8'h00)
		else $error("program sets a bit");
	a_prog_window: assert property (s_prog |-> fl_addr >= 24'h010000 && fl_addr <= 24'h7FFFFF)
		else $error("program outside user area");
	a_erase_sector: assert property (s_erase |-> fl_addr[15:0] == 16'h0000)
		else $error("erase address not a sector base");
	a_erase_range: assert property (s_erase |-> fl_addr[23:16] inside {[8'h01:8'h7F]})
		else $error("erase of a refused sector");
	a_fl_hold: assert property (fl_req && !fl_ack |=> fl_req && $stable(fl_op) && $stable(fl_addr))
		else $error("flash request changed before ack");
	a_rsp_pulse: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
		else $error("response not a one cycle pulse");
	a_busy_ready: assert property (mem_req || fl_req |-> !cmd_ready)
		else $error("ready while busy");
endmodule
bind mpf_top mpf_sva mpf_sva_i (.sys_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .flash_wr_enable,
	.rsp_valid, .rsp_err, .mem_req, .mem_ack, .fl_req, .fl_op, .fl_addr, .fl_wdata, .fl_ack,
	.fl_rdata);
`default_nettype wire

// file: mpf_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpf_regs.vh"
// ----
// Processor space, shared memory and flash
// ----
module mpf_partner (
	// Clock, reset, pacing
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic slow,
	// Processor space
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	output logic mem_ack,
	// Shared memory
	input wire logic shm_req,
	input wire logic [31:0] shm_addr,
	output logic shm_ack,
	output logic [7:0] shm_rdata,
	// Flash
	input wire logic fl_req,
	input wire logic [1:0] fl_op,
	input wire logic [23:0] fl_addr,
	input wire logic [7:0] fl_wdata,
	output logic fl_ack,
	output logic [7:0] fl_rdata
);
	logic [7:0] pm [logic [31:0]];
	logic [7:0] fl [logic [23:0]];
	logic [1:0] mc_q, fc_q;
	wire logic [1:0] lat = slow ? 2'h3 : 2'h0;
	// Idle data lines toggle so stale bytes never pass
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{mem_ack, shm_ack, fl_ack, mc_q, fc_q} <= '0;
			shm_rdata <= 8'h00;
			fl_rdata <= 8'h00;
		end else begin
			mem_ack <= 1'b0;
			fl_ack <= 1'b0;
			fl_rdata <= ~fl_rdata;
			shm_ack <= shm_req && !shm_ack;
			shm_rdata <= shm_req && !shm_ack ? shm_addr[7:0] ^ 8'h5A : ~shm_rdata;
			mc_q <= mem_req && !mem_ack ? mc_q + 2'h1 : 2'h0;
			fc_q <= fl_req && !fl_ack ? fc_q + 2'h1 : 2'h0;
			if (mem_req && !mem_ack && mc_q == lat) begin
				mem_ack <= 1'b1;
				for (int i = 0; i < 4; i++)
					if (mem_be[i]) pm[{mem_addr[31:2], 2'h0} + i] = mem_wdata[8 * i +: 8];
			end
			if (fl_req && !fl_ack && fc_q == lat) begin
				fl_ack <= 1'b1;
				case (fl_op)
				`MPF_FL_READ: fl_rdata <= fl.exists(fl_addr) ? fl[fl_addr] : 8'hFF;
				`MPF_FL_PROG: fl[fl_addr] = (fl.exists(fl_addr) ? fl[fl_addr] : 8'hFF) & fl_wdata;
				default: for (int i = 0; i < 65536; i++) fl.delete({fl_addr[23:16], 16'h0} + i);
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: mpf_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpf_regs.vh"
`define CHK(nm, e, g) begin n_checks++; \
	if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
// ----
// Bench
// ----
module mpf_top_tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, flash_wr_enable = 1'b0, slow = 1'b0;
	logic [2:0] cmd_op = 3'h0, cmd_width = 3'h0, w;
	logic [31:0] cmd_addr = '0, cmd_data = '0, cmd_ptr = '0, seed = 32'hC, a, d;
	logic [23:0] cmd_count = '0, fl_addr;
	logic cmd_ready, rsp_valid, rsp_err, mem_req, mem_ack, shm_req, shm_ack, fl_req, fl_ack;
	logic [7:0] rsp_data, shm_rdata, fl_wdata, fl_rdata, got_d;
	logic [31:0] mem_addr, mem_wdata, shm_addr;
	logic [3:0] mem_be;
	logic [1:0] fl_op;
	int n_fail = 0, n_checks = 0;
	mpf_top mpf_top_i (.sys_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_width,
		.cmd_data, .cmd_ptr, .cmd_count, .flash_wr_enable, .rsp_valid, .rsp_err, .rsp_data,
		.mem_req, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .shm_req, .shm_addr, .shm_ack,
		.shm_rdata, .fl_req, .fl_op, .fl_addr, .fl_wdata, .fl_ack, .fl_rdata);
	mpf_partner mpf_partner_i (.sys_clk, .rst, .slow, .mem_req, .mem_addr, .mem_wdata, .mem_be,
		.mem_ack, .shm_req, .shm_addr, .shm_ack, .shm_rdata, .fl_req, .fl_op, .fl_addr,
		.fl_wdata, .fl_ack, .fl_rdata);
	always #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_shm(input logic [31:0] p);
		return p[7:0] ^ 8'h5A;
	endfunction
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [31:0] ca, input logic [31:0] cd,
		input logic [2:0] cw, input logic [23:0] n, input logic e);
		int t;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		{cmd_op, cmd_addr, cmd_data, cmd_ptr, cmd_width, cmd_count} <= {op, ca, cd, cd, cw, n};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		for (t = 0; t < 4000; t++) begin
			@(negedge sys_clk);
			if (rsp_valid === 1'b1) break;
		end
		if (t == 4000) begin
			n_fail++;
			complete_run();
		end
		`CHK("rsp_err", e, rsp_err)
		got_d = rsp_data;
	endtask
	task automatic rd(input logic [31:0] ra, input logic [7:0] x);
		cmd(`MPF_OP_FRD, ra, '0, '0, '0, 1'b0);
		`CHK("flash byte", x, got_d)
	endtask
	initial begin
		mpf_partner_i.fl[24'h000010] = 8'h3C;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 24; i++) begin
			w = 3'h1 << (i % 3);
			slow <= i[0];
			a = rnd() & ~({29'h0, w} - 32'h1);
			d = rnd() >> (32 - 8 * w);
			cmd(`MPF_OP_MEMW, a, d, w, '0, 1'b0);
			for (int k = 0; k < w; k++)
				`CHK("mem byte", d[8 * k +: 8], mpf_partner_i.pm[a + k])
			if (w != 3'h1) cmd(`MPF_OP_MEMW, a + 32'h1, ~d, w, '0, 1'b1);
			if (!(i[2:0] inside {3'h1, 3'h2, 3'h4})) cmd(`MPF_OP_MEMW, a, ~d, i[2:0], '0, 1'b1);
			`CHK("mem kept", d[7:0], mpf_partner_i.pm[a])
		end
		cmd(`MPF_OP_FPRG, 32'h20000, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FERS, 32'h2, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FBLK, 32'h30000, '0, '0, 24'h4, 1'b1);
		slow <= 1'b0;
		@(posedge sys_clk);
		flash_wr_enable <= 1'b1;
		cmd(`MPF_OP_FERS, 32'h1, '0, '0, '0, 1'b0);
		d = rnd();
		cmd(`MPF_OP_FPRG, 32'h10005, d, '0, '0, 1'b0);
		rd(32'h10005, d[7:0]);
		cmd(`MPF_OP_FPRG, 32'h10005, d >> 8, '0, '0, 1'b0);
		rd(32'h10005, d[7:0] & d[15:8]);
		cmd(`MPF_OP_FPRG, 32'h1FFFF, '0, '0, '0, 1'b0);
		cmd(`MPF_OP_FPRG, 32'hFFFF, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FPRG, 32'h800000, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FPRG, 32'h1010000, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FRD, 32'h800000, '0, '0, '0, 1'b1);
		cmd(3'h5, 32'h10005, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FERS, 32'h0, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FERS, 32'h80, '0, '0, '0, 1'b1);
		cmd(`MPF_OP_FERS, 32'h7F, '0, '0, '0, 1'b0);
		cmd(`MPF_OP_FERS, 32'h2, '0, '0, '0, 1'b0);
		rd(32'h1FFFF, 8'h00);
		rd(32'h10, 8'h3C);
		rd(32'h7FFFFF, 8'hFF);
		cmd(`MPF_OP_FERS, 32'h1, '0, '0, '0, 1'b0);
		rd(32'h10005, 8'hFF);
		slow <= 1'b1;
		a = rnd();
		cmd(`MPF_OP_FBLK, 32'hFFF0, a, '0, 24'h4, 1'b1);
		cmd(`MPF_OP_FERS, 32'h3, '0, '0, '0, 1'b0);
		cmd(`MPF_OP_FBLK, 32'h3FFF6, a, '0, 24'h14, 1'b0);
		for (int k = 0; k < 20; k++)
			`CHK("block byte", exp_shm(a + k), mpf_partner_i.fl[24'h3FFF6 + k])
		cmd(`MPF_OP_FBLK, 32'h50000, a, '0, 24'h0, 1'b0);
		`CHK("empty block", 0, mpf_partner_i.fl.exists(24'h50000))
		cmd(`MPF_OP_FBLK, 32'h7FFFF0, a, '0, 24'h20, 1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
